// ===== design/spab_pkg.sv
// Constants and types for the setpoint alarm and bargraph logic
package spab_pkg;
// How it works
// (R1) Centre mode lights from the midpoint to the reading; midpoint lights one segment.
// (R2) Bipolar centre mode: positive readings grow up, negative grow down.
// (R3) Numeric readout off shows bar only; button press shows digits until procedure ends.
// (R4) Analog code never falls below floor; rises linearly above top to maximum.
// (R5) Floor limited to its mode range and kept strictly below top.
// (R6) Top limited to its mode range and kept strictly above floor.
// (R7) Floor to top maps linearly onto span readings; reversed span inverts output.
// (R8) Analog module presence is caught at power-up; absent means calibration skipped.
// (R9) Setpoints without relays still indicate; parked extremes never alarm.
// (R10) First relay energises after alarm held for the make delay; drop-out restarts.
// (R11) First relay releases after non-alarm held for break delay; re-alarm restarts.
// (R12) Only the first setpoint has delays; others switch at once.
// (R13) Every setpoint has its own deadband enable for relay switching.
// (R14) Band mode with second above first uses them as upper and lower limits.
// (R15) Fill pattern: on below first setpoint, stays on until second reached.
// (R16) Empty pattern: on above second setpoint, stays on until first reached.
// (R17) One high/low sense per setpoint; high alarms above, low alarms below.
// (R18) Tricolour bar shows one colour, the colour of the present zone.
// (R19) Own colour below lowest setpoint; each setpoint's colour when above it.
// (R20) Equal setpoints: highest-numbered setpoint's colour wins.
// (R21) Bargraph has 101 segments between programmable low and high readings.
// (R22) Above means strictly exceeds; highest-valued exceeded setpoint picks the zone.

  localparam int SEG_N   = 101;
  localparam int SEG_MID = 50;
  localparam int SP_N    = 4;

  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_SP      = 8'h04;
  localparam logic [7:0] OFS_DEADBAND_ENABLE    = 8'h14;
  localparam logic [7:0] OFS_DOM     = 8'h18;
  localparam logic [7:0] OFS_DOB     = 8'h1C;
  localparam logic [7:0] OFS_BARLO   = 8'h20;
  localparam logic [7:0] OFS_BARHI   = 8'h24;
  localparam logic [7:0] OFS_SPANBOT = 8'h28;
  localparam logic [7:0] OFS_SPANTOP = 8'h2C;
  localparam logic [7:0] OFS_FLOOR   = 8'h30;
  localparam logic [7:0] OFS_TOP     = 8'h34;
  localparam logic [7:0] OFS_COLOUR  = 8'h38;
  localparam logic [7:0] OFS_STATUS  = 8'h3C;
  localparam logic [7:0] OFS_READING = 8'h40;
  localparam logic [7:0] OFS_AOUT    = 8'h44;

  // Analog levels: microamps in current mode, millivolts in voltage mode
  localparam logic signed [15:0] FLOOR_MIN_UA = -16'sd300;
  localparam logic signed [15:0] FLOOR_MAX_UA = 16'sd18000;
  localparam logic signed [15:0] TOP_MIN_UA   = 16'sd18000;
  localparam logic signed [15:0] TOP_MAX_UA   = 16'sd24000;
  localparam logic signed [15:0] FLOOR_MIN_MV = -16'sd600;
  localparam logic signed [15:0] FLOOR_MAX_MV = 16'sd8000;
  localparam logic signed [15:0] TOP_MIN_MV   = 16'sd8000;
  localparam logic signed [15:0] TOP_MAX_MV   = 16'sd10300;
  localparam logic signed [15:0] FLOOR_RST_UA = 16'sd4000;
  localparam logic signed [15:0] TOP_RST_UA   = 16'sd20000;
  localparam logic signed [15:0] FLOOR_RST_MV = 16'sd0;
  localparam logic signed [15:0] TOP_RST_MV   = 16'sd10000;

  localparam logic signed [15:0] DEADBAND_ENABLE_RST  = 16'sd10;
  localparam logic signed [15:0] SPAN_RST  = 16'sd9999;
  localparam logic [13:0]        DELAY_MAX = 14'd9999;
  localparam logic [12:0]        CTRL_RST  = 13'h1002;

  localparam int CLK_HZ      = 100_000_000;
  localparam int TICK_S      = 1;
  localparam int TICK_CYCLES = TICK_S * CLK_HZ;

  typedef struct packed {
    logic       curMode;       // 1 current, 0 voltage
    logic [3:0] deadbandEn;
    logic [3:0] senseHigh;     // bit 0 is the first setpoint
    logic       bandMode;
    logic       numericEn;
    logic       centreMode;
  } ctrl_t;

  typedef enum logic [1:0] {
    COL_GREEN  = 2'b00,
    COL_ORANGE = 2'b01,
    COL_RED    = 2'b10
  } colour_t;

  typedef enum logic [1:0] {
    RLY_OFF   = 2'b00,
    RLY_MAKE  = 2'b01,
    RLY_ON    = 2'b10,
    RLY_BREAK = 2'b11
  } rly_t;
endpackage

// ===== design/spab_top.sv
// Setpoint alarms, delayed relay, bargraph, colour zone and analog output mapping
`timescale 1ns/10ps
module spab_top
  import spab_pkg::*;
#(
  parameter int TICKS = TICK_CYCLES
)(
  input  wire logic               ref_clk,      // System clock
  input  wire logic               nrst,         // Async reset, low
  input  wire logic [7:0]         addr,         // Register byte address
  input  wire logic [31:0]        wdata,        // Write data
  input  wire logic               wr,           // Write strobe
  input  wire logic               rd,           // Read strobe
  output logic      [31:0]        rdata,        // Read data, cycle after rd
  input  wire logic signed [15:0] reading,      // Converted reading
  input  wire logic               readingValid, // New reading pulse
  input  wire logic [3:0]         buttons,      // Front buttons, async
  input  wire logic               procDone,     // Menu procedure finished
  input  wire logic               aoutFitted,   // Analog module strap, async
  output logic [3:0]              relay,        // Relay drives
  output logic [3:0]              annun,        // Front annunciators
  output logic [SEG_N-1:0]        segments,     // Bargraph segments
  output colour_t                 colour,       // Bar colour
  output logic                    numericOn,    // Digit display enable
  output logic signed [15:0]      aoutCode,     // Analog output code
  output logic                    calSkip       // Skip analog calibration
);

  //--------------------------------------------------------------
  // Registers
  //--------------------------------------------------------------
  ctrl_t              ctrl_q;
  logic signed [15:0] sp_q [SP_N];
  logic signed [15:0] deadband_enable_q;
  logic [13:0]        dom_q;
  logic [13:0]        dob_q;
  logic signed [15:0] barLo_q;
  logic signed [15:0] barHi_q;
  logic signed [15:0] spanBot_q;
  logic signed [15:0] spanTop_q;
  logic signed [15:0] floor_q;
  logic signed [15:0] top_q;
  logic [9:0]         colSel_q;
  logic signed [15:0] rdg_q;

  wire signed [15:0] wv       = wdata[15:0];
  wire               wrCtrl   = wr && addr == OFS_CTRL;
  wire               wrHyst   = wr && addr == OFS_DEADBAND_ENABLE;
  wire               wrDom    = wr && addr == OFS_DOM;
  wire               wrDob    = wr && addr == OFS_DOB;
  wire               wrBarLo  = wr && addr == OFS_BARLO;
  wire               wrBarHi  = wr && addr == OFS_BARHI;
  wire               wrSpBot  = wr && addr == OFS_SPANBOT;
  wire               wrSpTop  = wr && addr == OFS_SPANTOP;
  wire               wrFloor  = wr && addr == OFS_FLOOR;
  wire               wrTop    = wr && addr == OFS_TOP;
  wire               wrColour = wr && addr == OFS_COLOUR;
  wire               modeFlip = wrCtrl && wdata[12] != ctrl_q.curMode;

  // Limits follow the output mode
  wire signed [15:0] flLo  = ctrl_q.curMode ? FLOOR_MIN_UA : FLOOR_MIN_MV;
  wire signed [15:0] flHi  = ctrl_q.curMode ? FLOOR_MAX_UA : FLOOR_MAX_MV;
  wire signed [15:0] tpLo  = ctrl_q.curMode ? TOP_MIN_UA : TOP_MIN_MV;
  wire signed [15:0] tpHi  = ctrl_q.curMode ? TOP_MAX_UA : TOP_MAX_MV;
  wire signed [15:0] flLim = wv < flLo ? flLo : (wv > flHi ? flHi : wv);
  wire signed [15:0] tpLim = wv < tpLo ? tpLo : (wv > tpHi ? tpHi : wv);
  wire signed [15:0] flNew = flLim >= top_q ? top_q - 16'sh0001 : flLim;   // [R5]
  wire signed [15:0] tpNew = tpLim <= floor_q ? floor_q + 16'sh0001 : tpLim; // [R6]
  // Mode change reloads defaults so the pair never sits outside the new range
  wire signed [15:0] flDef = wdata[12] ? FLOOR_RST_UA : FLOOR_RST_MV;
  wire signed [15:0] tpDef = wdata[12] ? TOP_RST_UA : TOP_RST_MV;
  wire [13:0]        dlyIn = wdata > 32'(DELAY_MAX) ? DELAY_MAX : wdata[13:0];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q    <= ctrl_t'(CTRL_RST[12:1]);
      deadband_enable_q    <= DEADBAND_ENABLE_RST;
      dom_q     <= 14'h0;
      dob_q     <= 14'h0;
      barLo_q   <= 16'sh0;
      barHi_q   <= SPAN_RST;
      spanBot_q <= 16'sh0;
      spanTop_q <= SPAN_RST;
      colSel_q  <= 10'h0;
    end else begin
      if (wrCtrl) ctrl_q <= ctrl_t'(wdata[12:1]);
      if (wrHyst) deadband_enable_q <= wv;
      if (wrDom) dom_q <= dlyIn;
      if (wrDob) dob_q <= dlyIn;
      if (wrBarLo) barLo_q <= wv;
      if (wrBarHi) barHi_q <= wv;
      if (wrSpBot) spanBot_q <= wv;
      if (wrSpTop) spanTop_q <= wv;
      if (wrColour) colSel_q <= wdata[9:0];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      floor_q <= FLOOR_RST_UA;
      top_q   <= TOP_RST_UA;
    end else if (modeFlip) begin
      floor_q <= flDef;
      top_q   <= tpDef;
    end else begin
      if (wrFloor) floor_q <= flNew;
      if (wrTop) top_q <= tpNew;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) rdg_q <= 16'sh0;
    else if (readingValid) rdg_q <= reading;
  end

  //--------------------------------------------------------------
  // Setpoint comparators
  //--------------------------------------------------------------
  logic [SP_N-1:0] alarm_q;
  logic [SP_N-1:0] alarmD;
  logic [SP_N-1:0] plainD;

  for (genvar i = 0; i < SP_N; i++) begin : g_sp
    wire               wrSp   = wr && addr == OFS_SP + 8'(4 * i);
    wire signed [16:0] r      = 17'(rdg_q);
    wire signed [16:0] s      = 17'(sp_q[i]);
    wire signed [16:0] h      = ctrl_q.deadbandEn[i] ? 17'(deadband_enable_q) : 17'sh0;       // [R13]
    wire               hiSet  = r > s;                                             // [R17]
    wire               hiStay = r > s - h;
    wire               loSet  = r < s;                                             // [R17]
    wire               loStay = r < s + h;
    wire               setOn  = ctrl_q.senseHigh[i] ? hiSet : loSet;
    wire               stayOn = ctrl_q.senseHigh[i] ? hiStay : loStay;
    assign plainD[i] = alarm_q[i] ? stayOn : setOn;

    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) sp_q[i] <= 16'sh0;
      else if (wrSp) sp_q[i] <= wv;
    end
  end

  // Band mode on the first relay
  wire bandOn = ctrl_q.bandMode && sp_q[1] > sp_q[0];                  // [R14]
  wire fillD  = alarm_q[0] ? rdg_q < sp_q[1] : rdg_q < sp_q[0];         // [R15]
  wire emptyD = alarm_q[0] ? rdg_q > sp_q[0] : rdg_q > sp_q[1];         // [R16]
  wire bandD  = ctrl_q.senseHigh[0] ? emptyD : fillD;

  assign alarmD = {plainD[3:1], bandOn ? bandD : plainD[0]};

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) alarm_q <= '0;
    else alarm_q <= alarmD;
  end

  //--------------------------------------------------------------
  // First relay make and break delays
  //--------------------------------------------------------------
  rly_t        rly_q;
  rly_t        rly_d;
  logic [31:0] secCnt_q;
  logic [13:0] delCnt_q;

  wire secEnd  = secCnt_q == 32'(TICKS - 1);
  wire makeEnd = secEnd && delCnt_q + 14'h0001 == dom_q;
  wire brkEnd  = secEnd && delCnt_q + 14'h0001 == dob_q;

  always_comb begin
    rly_d = rly_q;
    case (rly_q)
      RLY_OFF:   if (alarm_q[0]) rly_d = dom_q == 14'h0 ? RLY_ON : RLY_MAKE;
      RLY_MAKE:  if (!alarm_q[0]) rly_d = RLY_OFF;                     // [R10]
                 else if (makeEnd) rly_d = RLY_ON;                     // [R10]
      RLY_ON:    if (!alarm_q[0]) rly_d = dob_q == 14'h0 ? RLY_OFF : RLY_BREAK;
      RLY_BREAK: if (alarm_q[0]) rly_d = RLY_ON;                       // [R11]
                 else if (brkEnd) rly_d = RLY_OFF;                     // [R11]
      default:   rly_d = RLY_OFF;
    endcase
  end

  // Timers restart on every state change
  wire timing = rly_d == rly_q && (rly_q == RLY_MAKE || rly_q == RLY_BREAK);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rly_q    <= RLY_OFF;
      secCnt_q <= 32'h0;
      delCnt_q <= 14'h0;
    end else begin
      rly_q    <= rly_d;
      secCnt_q <= (!timing || secEnd) ? 32'h0 : secCnt_q + 32'h1;
      delCnt_q <= !timing ? 14'h0 : (secEnd ? delCnt_q + 14'h0001 : delCnt_q);
    end
  end

  wire relay0D = rly_d == RLY_ON || rly_d == RLY_BREAK;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      relay <= 4'h0;
      annun <= 4'h0;
    end else begin
      relay <= {alarmD[3:1], relay0D};                                 // [R12]
      annun <= alarmD;                                                 // [R9]
    end
  end

  //--------------------------------------------------------------
  // Bargraph
  //--------------------------------------------------------------
  wire signed [16:0] bSpan  = 17'(barHi_q) - 17'(barLo_q);
  wire signed [16:0] bOff   = 17'(rdg_q) - 17'(barLo_q);
  wire signed [24:0] bProd  = 25'(bOff) * 25'sd100;
  wire signed [24:0] bQuot  = bSpan == 17'sh0 ? 25'sh0 : bProd / 25'(bSpan);
  wire               below  = bQuot < 25'sh0;
  wire [6:0]         pos    = below ? 7'h0 : (bQuot > 25'sd100 ? 7'd100 : bQuot[6:0]); // [R21]
  wire [6:0]         mid    = 7'(SEG_MID);
  // Centre mode works for bipolar spans because the midpoint is the span centre
  wire [6:0]         cLow   = pos < mid ? pos : mid;                   // [R2]
  wire [6:0]         cHigh  = pos > mid ? pos : mid;                   // [R2]
  logic [SEG_N-1:0]  segD;

  for (genvar k = 0; k < SEG_N; k++) begin : g_seg
    localparam logic [6:0] KI = 7'(k);
    wire inCentre = KI >= cLow && KI <= cHigh;                         // [R1]
    wire inNormal = !below && KI <= pos;
    assign segD[k] = ctrl_q.centreMode ? inCentre : inNormal;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) segments <= '0;
    else segments <= segD;
  end

  //--------------------------------------------------------------
  // Colour zone
  //--------------------------------------------------------------
  colour_t colD;

  always_comb begin
    logic signed [15:0] best;
    logic               found;
    best  = 16'sh0;
    found = 1'b0;
    colD  = colour_t'(colSel_q[1:0]);                                  // [R19]
    for (int i = 0; i < SP_N; i++) begin
      // Ascending scan with >= lets the higher number win a tie
      if (rdg_q > sp_q[i] && (!found || sp_q[i] >= best)) begin         // [R22] [R20]
        best  = sp_q[i];
        found = 1'b1;
        colD  = colour_t'(colSel_q[2*i+2 +: 2]);                       // [R19]
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) colour <= COL_GREEN;
    else colour <= colD == 2'b11 ? COL_RED : colD;                     // [R18]
  end

  //--------------------------------------------------------------
  // Numeric display blanking
  //--------------------------------------------------------------
  logic [3:0] btnMeta_q;
  logic [3:0] btnSync_q;
  logic [3:0] btnPrev_q;
  logic       showNum_q;

  wire press = |(btnSync_q & ~btnPrev_q);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      btnMeta_q <= 4'h0;
      btnSync_q <= 4'h0;
      btnPrev_q <= 4'h0;
      showNum_q <= 1'b0;
      numericOn <= 1'b1;
    end else begin
      btnMeta_q <= buttons;
      btnSync_q <= btnMeta_q;
      btnPrev_q <= btnSync_q;
      // A press in the same cycle as procDone keeps digits lit
      showNum_q <= press | (showNum_q & ~procDone);                    // [R3]
      numericOn <= ctrl_q.numericEn | press | (showNum_q & ~procDone); // [R3]
    end
  end

  //--------------------------------------------------------------
  // Analog module strap
  //--------------------------------------------------------------
  logic       fitMeta_q;
  logic       fitSync_q;
  logic [1:0] capCnt_q;
  logic       fitted_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fitMeta_q <= 1'b0;
      fitSync_q <= 1'b0;
      capCnt_q  <= 2'h0;
      fitted_q  <= 1'b0;
      calSkip   <= 1'b1;
    end else begin
      fitMeta_q <= aoutFitted;
      fitSync_q <= fitMeta_q;
      // Caught once after the synchroniser fills; later changes are ignored
      if (capCnt_q != 2'h3) capCnt_q <= capCnt_q + 2'h1;
      if (capCnt_q == 2'h2) begin
        fitted_q <= fitSync_q;                                         // [R8]
        calSkip  <= ~fitSync_q;                                        // [R8]
      end
    end
  end

  //--------------------------------------------------------------
  // Analog output mapping
  //--------------------------------------------------------------
  wire signed [16:0] aSpan  = 17'(spanTop_q) - 17'(spanBot_q);
  wire signed [16:0] aOff   = 17'(rdg_q) - 17'(spanBot_q);
  wire signed [16:0] aRange = 17'(top_q) - 17'(floor_q);
  wire signed [33:0] aProd  = 34'(aOff) * 34'(aRange);
  // Negative span flips the slope, giving the inverted output
  wire signed [33:0] aQuot  = aSpan == 17'sh0 ? 34'sh0 : aProd / 34'(aSpan); // [R7]
  wire signed [33:0] aRaw   = 34'(floor_q) + aQuot;                    // [R7]
  wire signed [15:0] aMax   = ctrl_q.curMode ? TOP_MAX_UA : TOP_MAX_MV;
  wire signed [15:0] aD     = aRaw < 34'(floor_q) ? floor_q :          // [R4]
                              (aRaw > 34'(aMax) ? aMax : aRaw[15:0]);  // [R4]

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) aoutCode <= FLOOR_RST_UA;
    else aoutCode <= aD;
  end

  //--------------------------------------------------------------
  // Read port
  //--------------------------------------------------------------
  wire [31:0] status = {18'h0, numericOn, colour, fitted_q, rly_q, relay, annun};
  wire [2:0]  spIdx  = 3'(addr[7:2] - 6'h01);
  wire        isSp   = addr >= OFS_SP && addr < OFS_DEADBAND_ENABLE && addr[1:0] == 2'h0;
  wire [31:0] rdMux  =
      addr == OFS_CTRL    ? {19'h0, ctrl_q, 1'b0} :
      isSp                ? 32'(sp_q[spIdx[1:0]]) :
      addr == OFS_DEADBAND_ENABLE    ? 32'(deadband_enable_q) :
      addr == OFS_DOM     ? 32'(dom_q) :
      addr == OFS_DOB     ? 32'(dob_q) :
      addr == OFS_BARLO   ? 32'(barLo_q) :
      addr == OFS_BARHI   ? 32'(barHi_q) :
      addr == OFS_SPANBOT ? 32'(spanBot_q) :
      addr == OFS_SPANTOP ? 32'(spanTop_q) :
      addr == OFS_FLOOR   ? 32'(floor_q) :
      addr == OFS_TOP     ? 32'(top_q) :
      addr == OFS_COLOUR  ? 32'(colSel_q) :
      addr == OFS_STATUS  ? status :
      addr == OFS_READING ? 32'(rdg_q) :
      addr == OFS_AOUT    ? 32'(aoutCode) : 32'h0;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) rdata <= 32'h0;
    else rdata <= rd ? rdMux : 32'h0;
  end

endmodule

// ===== test/spab_top_chk.sv
// Port-level assertions for the setpoint alarm and bargraph block
`timescale 1ns/10ps
module spab_top_chk
  import spab_pkg::*;
#(
  parameter int TICKS = TICK_CYCLES
)(
  input wire logic               ref_clk,      // Clock
  input wire logic               nrst,         // Reset, low
  input wire logic               wr,           // Write strobe
  input wire logic               readingValid, // Reading pulse
  input wire logic [3:0]         buttons,      // Front buttons
  input wire logic               aoutFitted,   // Module strap
  input wire logic [3:0]         relay,        // Relay drives
  input wire logic [3:0]         annun,        // Annunciators
  input wire logic [SEG_N-1:0]   segments,     // Bargraph
  input wire colour_t            colour,       // Bar colour
  input wire logic               numericOn,    // Digits on
  input wire logic signed [15:0] aoutCode,     // Analog code
  input wire logic               calSkip       // No analog module
);
  // ----
  // Helpers
  // ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic [2:0] upCnt_q;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) upCnt_q <= 3'h0;
    else if (upCnt_q != 3'h7) upCnt_q <= upCnt_q + 3'h1;
  end
  // Three idle cycles drain the two-stage reading path
  sequence quiet_s;
    (!readingValid && !wr) [*3];
  endsequence
  sequence press_s;
    $rose(|buttons);
  endsequence

  relay_sync_a: assert property (relay[3:1] == annun[3:1])
    else $error("undelayed relay differs from alarm");
  make_cause_a: assert property ($rose(relay[0]) |-> $past(annun[0]))
    else $error("first relay made without alarm");
  break_cause_a: assert property ($fell(relay[0]) |-> !$past(annun[0]))
    else $error("first relay broke during alarm");
  colour_one_a: assert property (colour != 2'b11)
    else $error("illegal bar colour");
  aout_range_a: assert property (aoutCode >= -16'sd600 && aoutCode <= 16'sd24000)
    else $error("analog code out of range");
  quiet_hold_a: assert property (quiet_s |=> $stable(annun) && $stable(segments) && $stable(colour))
    else $error("display changed without a cause");
  numeric_wake_a: assert property (press_s |-> ##[1:8] numericOn)
    else $error("button did not wake digits");
  strap_hold_a: assert property (upCnt_q == 3'h7 |-> calSkip == !aoutFitted && $stable(calSkip))
    else $error("calibration skip wrong");
endmodule

bind spab_top spab_top_chk #(.TICKS(TICKS)) spab_top_chk_i (.ref_clk, .nrst, .wr, .readingValid, .buttons,
  .aoutFitted, .relay, .annun, .segments, .colour, .numericOn, .aoutCode, .calSkip);

// ===== test/tb_top.sv
// Self-checking bench for the setpoint alarm and bargraph block
`timescale 1ns/10ps
module tb_top;
  import spab_pkg::*;
  // ----
  // Signals and tables
  // ----
  logic               ref_clk, nrst, wr, rd, readingValid, procDone, aoutFitted;
  logic               calSkip, numericOn;
  logic [7:0]         addr;
  logic [31:0]        wdata, rdata;
  logic signed [15:0] reading, aoutCode;
  logic [3:0]         buttons, relay, annun;
  logic [SEG_N-1:0]   segments;
  colour_t            colour;
  int                 err_total, cmp_count, cyc;
  int                 crd[5] = '{50, 150, 250, 350, 450};
  colour_t            cex[5] = '{COL_GREEN, COL_ORANGE, COL_RED, COL_GREEN, COL_RED};
  int                 br[7]  = '{5000, 7500, 2500, 0, -500, 500, 1000};
  int                 bl[7]  = '{50, 50, 25, 50, 25, 50, 0};
  int                 bh[7]  = '{50, 75, 50, 50, 50, 75, 100};
  int                 ar[5]  = '{-500, 0, 5000, 9999, 12000};

  // Short tick so the make and break delays run in tens of cycles
  spab_top #(.TICKS(10)) spab_top_i (.ref_clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .reading, .readingValid,
    .buttons, .procDone, .aoutFitted, .relay, .annun, .segments, .colour, .numericOn, .aoutCode, .calSkip);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  // ----
  // Tasks
  // ----
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask

  task automatic rdg(input int v);
    @(posedge ref_clk);
    readingValid <= 1'b1;
    reading      <= 16'(v);
    @(posedge ref_clk);
    readingValid <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  task automatic sps(input int a, input int b, input int c, input int d);
    wrr(OFS_SP, 32'(a));
    wrr(OFS_SP + 8'h4, 32'(b));
    wrr(OFS_SP + 8'h8, 32'(c));
    wrr(OFS_SP + 8'hC, 32'(d));
  endtask

  task automatic seq0(input int r[5], input logic [4:0] e);
    for (int i = 0; i < 5; i++) begin
      rdg(r[i]);
      chk(annun[0], e[i]);
    end
  endtask

  task automatic pulse_done();
    @(posedge ref_clk);
    procDone <= 1'b1;
    @(posedge ref_clk);
    procDone <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  function automatic logic [31:0] ctl(logic [3:0] db, logic [3:0] sh, logic band, logic num, logic cen);
    return {19'h0, 1'b1, db, sh, band, num, cen, 1'b0};
  endfunction

  function automatic int aexp(int r, int b, int t);
    int v;
    v = 4000 + ((r - b) * 16000) / (t - b);
    return v < 4000 ? 4000 : (v > 24000 ? 24000 : v);
  endfunction

  function automatic logic [127:0] seg(int lo, int hi);
    return ((128'h1 << (hi + 1)) - 128'h1) ^ ((128'h1 << lo) - 128'h1);
  endfunction

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    {nrst, wr, rd, readingValid, procDone, addr, wdata, reading, buttons} = '0;
    aoutFitted = 1'b1;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    wt(6);
    rdc(OFS_CTRL, 32'h1002);
    rdc(8'hFC, 32'h0);
    chk(calSkip, 1'b0);
    $display("Test reset done");
    wrr(OFS_CTRL, ctl(4'h0, 4'hF, 1'b0, 1'b1, 1'b0));
    sps(100, 200, 300, 400);
    rdg(250);
    chk(annun, 4'h3);
    chk(relay, 4'h3);
    wrr(OFS_SP + 8'hC, 32'd9999);
    rdg(9999);
    chk(annun, 4'h7);
    wrr(OFS_CTRL, ctl(4'h0, 4'h0, 1'b0, 1'b1, 1'b0));
    rdg(250);
    chk(annun, 4'hC);
    wrr(OFS_CTRL, ctl(4'h1, 4'hF, 1'b0, 1'b1, 1'b0));
    seq0('{105, 95, 90, 95, 110}, 5'b10011);
    wrr(OFS_CTRL, ctl(4'h0, 4'hE, 1'b1, 1'b1, 1'b0));
    seq0('{50, 150, 250, 150, 50}, 5'b10011);
    wrr(OFS_CTRL, ctl(4'h0, 4'hF, 1'b1, 1'b1, 1'b0));
    seq0('{250, 150, 50, 150, 250}, 5'b10011);
    $display("Test alarms done");
    wrr(OFS_CTRL, ctl(4'h0, 4'hF, 1'b0, 1'b1, 1'b0));
    wrr(OFS_DOM, 32'd2);
    wrr(OFS_DOB, 32'd1);
    rdg(50);
    wt(12);
    rdg(150);
    wt(8);
    chk(relay[0], 1'b0);
    rdg(50);
    rdg(150);
    wt(3);
    chk(relay[0], 1'b0);
    wt(20);
    chk(relay[0], 1'b1);
    rdg(50);
    chk(relay[0], 1'b1);
    wt(15);
    chk(relay[0], 1'b0);
    $display("Test delays done");
    wrr(OFS_COLOUR, 32'h224);
    sps(100, 200, 300, 400);
    for (int i = 0; i < 5; i++) begin
      rdg(crd[i]);
      chk(colour, cex[i]);
    end
    sps(400, 200, 300, 100);
    rdg(450);
    chk(colour, COL_ORANGE);
    sps(100, 200, 200, 400);
    rdg(250);
    chk(colour, COL_GREEN);
    $display("Test colour done");
    wrr(OFS_CTRL, ctl(4'h0, 4'hF, 1'b0, 1'b1, 1'b1));
    for (int i = 0; i < 7; i++) begin
      if (i == 3) begin
        wrr(OFS_BARLO, 32'hFFFFFC18);
        wrr(OFS_BARHI, 32'd1000);
      end
      if (i == 6) wrr(OFS_CTRL, ctl(4'h0, 4'hF, 1'b0, 1'b1, 1'b0));
      rdg(br[i]);
      chk(segments, seg(bl[i], bh[i]));
    end
    $display("Test bargraph done");
    for (int j = 0; j < 2; j++) begin
      wrr(OFS_SPANBOT, j ? 32'd9999 : 32'd0);
      wrr(OFS_SPANTOP, j ? 32'd0 : 32'd9999);
      for (int i = 0; i < 5; i++) begin
        rdg(ar[i]);
        chk(aoutCode, aexp(ar[i], j ? 9999 : 0, j ? 0 : 9999));
      end
    end
    wrr(OFS_FLOOR, 32'd30000);
    rdc(OFS_FLOOR, 32'd18000);
    wrr(OFS_TOP, 32'd100);
    rdc(OFS_TOP, 32'd18001);
    wrr(OFS_FLOOR, 32'hFFFFFC18);
    rdc(OFS_FLOOR, 32'hFFFFFED4);
    wrr(OFS_TOP, 32'd30000);
    rdc(OFS_TOP, 32'd24000);
    $display("Test analog done");
    wrr(OFS_CTRL, ctl(4'h0, 4'hF, 1'b0, 1'b0, 1'b0));
    pulse_done();
    chk(numericOn, 1'b0);
    buttons <= 4'h2;
    wt(8);
    chk(numericOn, 1'b1);
    buttons <= 4'h0;
    pulse_done();
    chk(numericOn, 1'b0);
    $display("Test numeric done");
    report_and_stop();
  end
endmodule
